/* File: hdl/epci_top.v */
/*
 * External and pin change interrupt logic with an APB register slave.
 * Assumes pins are asynchronous; cpu_irq_ack pulses come from the core.
 */
// What this block does
// - sense register: pin 1 mode in bits 3:2, pin 0 mode in 1:0.
// - mode 00 low level, 01 any change, 10 falling, 11 rising edge.
// - pins sampled before edge detection; pulses over one clock caught.
// - external request needs its enable bit and the global flag.
// - pin activity raises requests even when the pin is an output.
// - edge flags set on qualifying edges whether or not enabled.
// - a flag clears when the core enters its interrupt routine.
// - writing one clears a flag; writing zero leaves it.
// - flag of a pin in low-level mode is held cleared.
// - group 1 requests on masked change of inputs 15..8.
// - group 0 requests on masked change of inputs 7..0.
// - group flag set on change; vectoring needs enable and global.
// - high mask bit n enables input 8+n.
// - low mask bit n enables input n.
// - unused bits read zero; sense and masks reset to zero.
// - pin change detect raised even with clock enable low.
// - edges need the clock; low level does not.
`include "epci_regs.vh"

module epci_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [1:0]  ext_irq_pin,
    input  wire [7:0]  change_inputs_high,
    input  wire [7:0]  change_inputs_low,
    input  wire        global_irq_enable,
    input  wire [3:0]  cpu_irq_ack,
    output wire        ext_irq0_req,
    output wire        ext_irq1_req,
    output wire        change_group0_req,
    output wire        change_group1_req,
    output wire        wake_req
);
    reg  [3:0]  sense_reg;
    reg  [1:0]  ext_en_reg;
    reg  [1:0]  ext_flag_reg;
    reg  [1:0]  grp_en_reg;
    reg  [1:0]  grp_flag_reg;
    reg  [7:0]  mask_hi_reg;
    reg  [7:0]  mask_lo_reg;
    reg  [1:0]  ext_prev_reg;
    reg  [15:0] chg_prev_reg;
    reg  [1:0]  ext_flag_next;
    reg  [1:0]  grp_flag_next;
    reg  [31:0] rdata_next;

    wire [1:0]  ext_sync;
    wire [15:0] chg_sync;
    wire [1:0]  ext_edge;
    wire [1:0]  ext_level;
    wire [15:0] chg_diff;
    wire [1:0]  grp_hit;
    wire        wr_en;
    wire        rd_en;
    wire [1:0]  ext_w1c;
    wire [1:0]  grp_w1c;
    wire [1:0]  mode0;
    wire [1:0]  mode1;

    function low_mode;
        input [1:0] m;
        begin
            low_mode = (m == `EPCI_MODE_LOW);
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel & penable & pwrite & clk_en;
    assign rd_en   = psel & ~pwrite;

    assign mode0 = sense_reg[`EPCI_SENSE0_LSB+1:`EPCI_SENSE0_LSB];
    assign mode1 = sense_reg[`EPCI_SENSE1_LSB+1:`EPCI_SENSE1_LSB];

    // pins read regardless of port direction
    epci_sync #(.W(2)) u_ext_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .pin_async (ext_irq_pin),
        .pin_sync  (ext_sync)
    );

    epci_sync #(.W(16)) u_chg_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .pin_async ({change_inputs_high, change_inputs_low}),
        .pin_sync  (chg_sync)
    );

    epci_sense u_sense0 (
        .mode      (mode0),
        .cur       (ext_sync[0]),
        .prev      (ext_prev_reg[0]),
        .pin_raw   (ext_irq_pin[0]),
        .edge_hit  (ext_edge[0]),
        .level_req (ext_level[0])
    );

    epci_sense u_sense1 (
        .mode      (mode1),
        .cur       (ext_sync[1]),
        .prev      (ext_prev_reg[1]),
        .pin_raw   (ext_irq_pin[1]),
        .edge_hit  (ext_edge[1]),
        .level_req (ext_level[1])
    );

    // upper mask gates inputs 15..8, lower mask gates inputs 7..0
    assign chg_diff = (chg_sync ^ chg_prev_reg) &
                      {mask_hi_reg, mask_lo_reg};
    assign grp_hit[1] = |chg_diff[15:8];
    assign grp_hit[0] = |chg_diff[7:0];

    assign ext_w1c = (wr_en && paddr == `EPCI_OFF_EXT_FLAG) ?
                     pwdata[1:0] : 2'h0;
    assign grp_w1c = (wr_en && paddr == `EPCI_OFF_GRP_FLAG) ?
                     pwdata[1:0] : 2'h0;

    always @* begin
        // set wins over both clear sources
        ext_flag_next = (ext_flag_reg & ~ext_w1c &
                         ~cpu_irq_ack[`EPCI_ACK_EXT1:`EPCI_ACK_EXT0])
                        | ext_edge;
        if (low_mode(mode0))
            ext_flag_next[0] = 1'b0;
        if (low_mode(mode1))
            ext_flag_next[1] = 1'b0;
        grp_flag_next = (grp_flag_reg & ~grp_w1c &
                         ~cpu_irq_ack[`EPCI_ACK_GRP1:`EPCI_ACK_GRP0])
                        | grp_hit;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_reg    <= `EPCI_SENSE_RESET;
            ext_en_reg   <= `EPCI_EN_RESET;
            grp_en_reg   <= `EPCI_EN_RESET;
            mask_hi_reg  <= `EPCI_MASK_RESET;
            mask_lo_reg  <= `EPCI_MASK_RESET;
            ext_flag_reg <= 2'h0;
            grp_flag_reg <= 2'h0;
            ext_prev_reg <= 2'h0;
            chg_prev_reg <= 16'h0000;
        end else if (clk_en) begin
            ext_prev_reg <= ext_sync;
            chg_prev_reg <= chg_sync;
            ext_flag_reg <= ext_flag_next;
            grp_flag_reg <= grp_flag_next;
            if (wr_en) begin
                case (paddr)
                    `EPCI_OFF_SENSE:   sense_reg   <= pwdata[3:0];
                    `EPCI_OFF_EXT_EN:  ext_en_reg  <= pwdata[1:0];
                    `EPCI_OFF_GRP_EN:  grp_en_reg  <= pwdata[1:0];
                    `EPCI_OFF_MASK_HI: mask_hi_reg <= pwdata[7:0];
                    `EPCI_OFF_MASK_LO: mask_lo_reg <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    always @* begin
        rdata_next = 32'h00000000;
        case (paddr)
            `EPCI_OFF_SENSE:     rdata_next[3:0] = sense_reg;
            `EPCI_OFF_EXT_EN:    rdata_next[1:0] = ext_en_reg;
            `EPCI_OFF_EXT_FLAG:  rdata_next[1:0] = ext_flag_reg;
            `EPCI_OFF_GRP_EN:    rdata_next[1:0] = grp_en_reg;
            `EPCI_OFF_GRP_FLAG:  rdata_next[1:0] = grp_flag_reg;
            `EPCI_OFF_MASK_HI:   rdata_next[7:0] = mask_hi_reg;
            `EPCI_OFF_MASK_LO:   rdata_next[7:0] = mask_lo_reg;
            default:             rdata_next = 32'h00000000;
        endcase
    end

    // read data captured in the setup cycle, valid in the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_en && !penable && clk_en)
            prdata <= rdata_next;
    end

    // a stale edge flag must not leak out in the cycle a pin enters low mode
    assign ext_irq0_req = global_irq_enable & ext_en_reg[0] &
        ((ext_flag_reg[0] & ~low_mode(mode0)) | ext_level[0]);
    assign ext_irq1_req = global_irq_enable & ext_en_reg[1] &
        ((ext_flag_reg[1] & ~low_mode(mode1)) | ext_level[1]);
    assign change_group0_req = global_irq_enable & grp_en_reg[0] &
                               grp_flag_reg[0];
    assign change_group1_req = global_irq_enable & grp_en_reg[1] &
                               grp_flag_reg[1];

    // combinational wake path, usable while the clock is gated
    assign wake_req =
        (|(({change_inputs_high, change_inputs_low} ^ chg_prev_reg) &
           {mask_hi_reg, mask_lo_reg}) & |grp_en_reg)
        | (|(ext_level & ext_en_reg));
endmodule // epci_top

/* File: hdl/epci_regs.vh */
/*
 * Register offsets, field positions, reset values and sense codes for the
 * external and pin change interrupt block.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`ifndef EPCI_REGS_VH
`define EPCI_REGS_VH

`define EPCI_OFF_SENSE      12'h000
`define EPCI_OFF_EXT_EN     12'h004
`define EPCI_OFF_EXT_FLAG   12'h008
`define EPCI_OFF_GRP_EN     12'h00C
`define EPCI_OFF_GRP_FLAG   12'h010
`define EPCI_OFF_MASK_HI    12'h014
`define EPCI_OFF_MASK_LO    12'h018
`define EPCI_OFF_ACK        12'h01C

`define EPCI_SENSE1_LSB     2
`define EPCI_SENSE0_LSB     0
`define EPCI_SENSE_RESET    4'h0
`define EPCI_MASK_RESET     8'h00
`define EPCI_EN_RESET       2'h0

`define EPCI_MODE_LOW       2'h0
`define EPCI_MODE_ANY       2'h1
`define EPCI_MODE_FALL      2'h2
`define EPCI_MODE_RISE      2'h3

`define EPCI_ACK_EXT0       0
`define EPCI_ACK_EXT1       1
`define EPCI_ACK_GRP0       2
`define EPCI_ACK_GRP1       3

`endif

/* File: hdl/epci_sync.v */
/*
 * Two-stage synchroniser for a vector of pin inputs.
 * Assumes the inputs are asynchronous to pclk.
 */
module epci_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         clk_en,
    input  wire [W-1:0] pin_async,
    output reg  [W-1:0] pin_sync
);
    reg [W-1:0] meta_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {W{1'b0}};
            pin_sync <= {W{1'b0}};
        end else if (clk_en) begin
            meta_reg <= pin_async;
            pin_sync <= meta_reg;
        end
    end
endmodule // epci_sync

/* File: hdl/epci_sense.v */
/*
 * Trigger decode for one external interrupt pin from its two-bit mode.
 * Assumes cur and prev are synchronised samples one pclk apart.
 */
`include "epci_regs.vh"

module epci_sense (
    input  wire [1:0] mode,
    input  wire       cur,
    input  wire       prev,
    input  wire       pin_raw,
    output reg        edge_hit,
    output reg        level_req
);
    always @* begin
        edge_hit  = 1'b0;
        level_req = 1'b0;
        case (mode)
            `EPCI_MODE_LOW:  level_req = ~pin_raw;
            `EPCI_MODE_ANY:  edge_hit  = cur ^ prev;
            `EPCI_MODE_FALL: edge_hit  = prev & ~cur;
            `EPCI_MODE_RISE: edge_hit  = ~prev & cur;
            default:         edge_hit  = 1'b0;
        endcase
    end
endmodule // epci_sense

/* File: tb/epci_props.sv */
/* assertions for epci_top, seen at its ports only
   assumes binding to epci_top and the APB map of epci_regs.vh */
`include "epci_regs.vh"
module epci_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [1:0]  ext_irq_pin,
    input wire logic        global_irq_enable,
    input wire logic        ext_irq0_req,
    input wire logic        ext_irq1_req,
    input wire logic        change_group0_req,
    input wire logic        change_group1_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] sen;
    logic [1:0] een;
    logic [1:0] gen;
    wire wr = psel && penable && pwrite && clk_en;
    wire glb = global_irq_enable;
    // shadow copies of the sense and enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sen <= 4'h0;
            een <= 2'h0;
            gen <= 2'h0;
        end else if (wr) begin
            if (paddr == `EPCI_OFF_SENSE) sen <= pwdata[3:0];
            if (paddr == `EPCI_OFF_EXT_EN) een <= pwdata[1:0];
            if (paddr == `EPCI_OFF_GRP_EN) gen <= pwdata[1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    gate_ext0_a: assert property (ext_irq0_req |-> glb && een[0])
        else $error("ext0 request without its enables");
    gate_ext1_a: assert property (ext_irq1_req |-> glb && een[1])
        else $error("ext1 request without its enables");
    gate_grp0_a: assert property (change_group0_req |-> glb && gen[0])
        else $error("group0 request without its enables");
    gate_grp1_a: assert property (change_group1_req |-> glb && gen[1])
        else $error("group1 request without its enables");
    low_req_a: assert property (sen[1:0] == `EPCI_MODE_LOW && een[0] && glb
        && !ext_irq_pin[0] |-> ext_irq0_req)
        else $error("low level gave no request");
    low_flag_a: assert property (sen[1:0] == `EPCI_MODE_LOW
        && ext_irq_pin[0] |-> !ext_irq0_req)
        else $error("request in low mode with pin high");
    rise_req_a: assert property (sen[1:0] == `EPCI_MODE_RISE && een[0] && glb
        && clk_en && $rose(ext_irq_pin[0]) |-> ##[1:4] ext_irq0_req)
        else $error("rising edge gave no request");
    rd_zero_a: assert property (psel && penable && !pwrite
        && paddr == `EPCI_OFF_SENSE |-> prdata[31:4] == 28'h0)
        else $error("unused sense bits read nonzero");
    cover property (ext_irq0_req && clk_en);
    cover property (ext_irq1_req && !clk_en);
    cover property (change_group1_req);
endmodule // epci_props
bind epci_top epci_props i_props (.*);

/* File: tb/epci_pins.sv */
/* board-side model of the interrupt and pin change inputs
   assumes the bench sets the wanted levels at a rising edge */
module epci_pins (
    input  wire logic        pclk,
    input  wire logic [17:0] want,
    output logic      [17:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = 18'h0;
    // levels are held until the bench asks for new ones
    always @(posedge pclk) pins <= want;
endmodule // epci_pins

/* File: tb/tb_top.sv */
/* self-checking bench for epci_top
   assumes zero-wait APB and flags visible 3 edges after a pin change */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, clk_en = 1, glb = 0;
    logic        psel = 0, penable = 0, pwrite = 0, smp = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, h;
    logic        pready, pslverr, wake_req;
    logic [3:0]  ack = 4'h0, req, e;
    logic [17:0] want = 18'h0, pins;
    logic [31:0] rq[$];
    logic [3:0]  eq[$];
    int          failures = 0, num_checks = 0, seed = 32'hc5b7;
    epci_pins i_pins (.pclk(pclk), .want(want), .pins(pins));
    epci_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_pin(pins[17:16]),
        .change_inputs_high(pins[15:8]), .change_inputs_low(pins[7:0]),
        .global_irq_enable(glb), .cpu_irq_ack(ack),
        .ext_irq0_req(req[0]), .ext_irq1_req(req[1]),
        .change_group0_req(req[2]), .change_group1_req(req[3]),
        .wake_req(wake_req));
    initial forever #12.5 pclk = ~pclk;
    task cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            failures++;
            $display("unexpected %s exp %h got %h", n, x, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] x);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) rq.push_back(x);
        @(posedge pclk) penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d, 0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0, x);
    endtask
    task chk(input logic [3:0] x);
        @(posedge pclk) smp <= 1;
        eq.push_back(x);
        @(posedge pclk) smp <= 0;
    endtask
    task pin(input logic [17:0] v);
        @(posedge pclk) want <= v;
        repeat (5) @(posedge pclk);
    endtask
    task pulse(input logic [3:0] v);
        @(posedge pclk) ack <= v;
        @(posedge pclk) ack <= 4'h0;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && rq.size() > 0)
            cmp("prdata", rq.pop_front(), prdata);
        if (smp && eq.size() > 0) cmp("requests", eq.pop_front(), req);
    end
    initial begin
        #1000000;
        failures++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (int a = 0; a < 8; a++) rd(12'(a * 4), 0);
        wr(12'h000, 32'hFF);
        rd(12'h000, 32'h0F);
        wr(12'h004, 32'hFF);
        rd(12'h004, 32'h03);
        wr(12'h004, 0);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            wr(12'h000, 32'(m * 5));
            wr(12'h008, 3);
            pin(18'h30000);
            rd(12'h008, (m % 2 == 1) ? 3 : 0);
            wr(12'h008, 3);
            pin(18'h0);
            rd(12'h008, (m == 1 || m == 2) ? 3 : 0);
        end
        $display("test sense modes done");
        pin(18'h30000);
        wr(12'h008, 1);
        rd(12'h008, 2);
        wr(12'h008, 0);
        rd(12'h008, 2);
        wr(12'h004, 2);
        chk(4'h0);
        @(posedge pclk) glb <= 1;
        chk(4'h2);
        pulse(4'h2);
        chk(4'h0);
        wr(12'h000, 32'h0F);
        wr(12'h004, 3);
        pin(18'h0);
        pin(18'h30000);
        chk(4'h3);
        wr(12'h008, 3);
        wr(12'h000, 0);
        @(posedge pclk) clk_en <= 0;
        pin(18'h0);
        cmp("wake_req", 1, wake_req);
        chk(4'h3);
        @(posedge pclk) clk_en <= 1;
        $display("test flags and gating done");
        wr(12'h004, 0);
        wr(12'h00C, 3);
        repeat (4) begin
            r = $random(seed);
            h = $random(seed);
            wr(12'h018, r[7:0]);
            wr(12'h014, h[7:0]);
            wr(12'h010, 3);
            pin(want ^ {2'b00, h[23:16], r[23:16]});
            e = {|(h[23:16] & h[7:0]), |(r[23:16] & r[7:0]), 2'b00};
            rd(12'h010, e[3:2]);
            chk(e);
        end
        wr(12'h018, 32'hFF);
        pin(want ^ 18'h1);
        pulse(4'hC);
        chk(4'h0);
        $display("test pin change done");
        end_of_test;
    end
endmodule // tb_top
